// ### common/dlm_pkg.sv
// shared constants for the data lane strobe and mask block
package dlm_pkg;
   // die organisation: x16 per channel, eight banks, two channels
   localparam int NUM_CH = 2;
   localparam int DQ_W = 16;
   localparam int BYTE_W = 8;
   localparam int LANES = DQ_W / BYTE_W;
   localparam int NUM_BANKS = 8;
   localparam int BANK_W = $clog2(NUM_BANKS);

   // command/address bus field layout on the link
   localparam int CMD_W = 6;
   localparam int OP_LSB = 0;
   localparam int OP_W = 3;
   localparam int BANK_LSB = 3;

   // command opcodes carried in the op field
   localparam logic [OP_W-1:0] OP_WRITE = 3'h1;
   localparam logic [OP_W-1:0] OP_MASK_WRITE = 3'h2;

   // a byte with more ones than this is sent inverted
   localparam int INV_THRESH = 4;

   // reset values of the link-facing outputs
   localparam logic STROBE_RST = 1'b0;
   localparam logic [BYTE_W-1:0] DQ_RST = 8'h00;
   localparam logic MASK_LINE_RST = 1'b0;
endpackage : dlm_pkg

// ### rtl/dlm_data_lane.sv
// data lane, strobe and mask/inversion logic of a two-channel x16 memory die
//
// Summary of operation
// - memory drives strobe edge-aligned with read data
// - one strobe pair per byte, per channel
// - mask line high means byte inverted
// - inversion can be switched off by mode
// - masked write: line marks bytes not stored
// - masking switched off independently by mode
// - one mask line per byte, per channel
// - reset low resets every channel together
// - sixteen data bits and eight banks
// - commands sampled on rising true clock
`timescale 1ns/100ps
`default_nettype none

module dlm_data_lane #(
   parameter int NUM_CH = dlm_pkg::NUM_CH,
   parameter int DQ_W = dlm_pkg::DQ_W
) (
   // core clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // core read data toward the link
   input wire logic rd_valid,
   input wire logic [NUM_CH*DQ_W-1:0] rd_data,
   output logic rd_ready,
   // core write data from the link, one set per channel
   output logic [NUM_CH-1:0] wr_valid,
   output logic [NUM_CH*DQ_W-1:0] wr_data,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] wr_keep,
   output logic [NUM_CH*dlm_pkg::BANK_W-1:0] wr_bank,
   // mode settings, quasi-static levels
   input wire logic bus_inversion_rd_en,
   input wire logic bus_inversion_wr_en,
   input wire logic write_byte_mask_en,
   // link clock and command pins
   input wire logic clock_true,
   input wire logic [NUM_CH-1:0] chip_sel,
   input wire logic [NUM_CH*dlm_pkg::CMD_W-1:0] cmd_addr_bus,
   // data pins
   input wire logic [NUM_CH*DQ_W-1:0] dq_i,
   output logic [NUM_CH*DQ_W-1:0] dq_o,
   output logic [NUM_CH*DQ_W-1:0] dq_oe,
   // byte strobe pairs
   input wire logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] strobe_t_i,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] strobe_t_o,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] strobe_t_oe,
   input wire logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] strobe_c_i,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] strobe_c_o,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] strobe_c_oe,
   // mask/inversion lines, one per byte
   input wire logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] mask_invert_line_i,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] mask_invert_line_o,
   output logic [NUM_CH*(DQ_W/dlm_pkg::BYTE_W)-1:0] mask_invert_line_oe
);

   localparam int BW = dlm_pkg::BYTE_W;
   localparam int NL = NUM_CH * (DQ_W / BW);
   localparam int CW = dlm_pkg::CMD_W;
   localparam int BKW = dlm_pkg::BANK_W;

   // link-domain reset and mode synchronisers
   // modes are quasi-static levels, so a plain two-flop chain per bit is enough
   logic lrst_s1_r;
   logic lrst_s2_r;
   logic [2:0] mode_s1_r;
   logic [2:0] mode_s2_r;
   logic lrst_n;
   logic inv_rd_l;
   logic inv_wr_l;
   logic mask_en_l;

   // pin reset carried onto the link clock; no reset term on the chain itself
   always_ff @(posedge clock_true) begin
      lrst_s1_r <= reset_n;
      lrst_s2_r <= lrst_s1_r;
      mode_s1_r <= {write_byte_mask_en, bus_inversion_wr_en, bus_inversion_rd_en};
      mode_s2_r <= mode_s1_r;
   end

   assign lrst_n = lrst_s2_r;
   assign inv_rd_l = mode_s2_r[0];
   assign inv_wr_l = mode_s2_r[1];
   assign mask_en_l = mode_s2_r[2];

   // core-domain state
   // words cross by toggle handshakes only, never sampled while they move
   logic rd_req_r;
   logic rd_req_nxt;
   logic [NUM_CH*DQ_W-1:0] rd_hold_r;
   logic [NUM_CH*DQ_W-1:0] rd_hold_nxt;
   logic rd_ack_s1_r;
   logic rd_ack_s2_r;
   logic [NUM_CH-1:0] wr_tog_s1_r;
   logic [NUM_CH-1:0] wr_tog_s2_r;
   logic [NUM_CH-1:0] wr_tog_s3_r;
   logic [NUM_CH-1:0] wr_valid_r;
   logic [NUM_CH-1:0] wr_valid_nxt;
   logic [NUM_CH*DQ_W-1:0] wr_data_r;
   logic [NUM_CH*DQ_W-1:0] wr_data_nxt;
   logic [NL-1:0] wr_keep_r;
   logic [NL-1:0] wr_keep_nxt;
   logic [NUM_CH*BKW-1:0] wr_bank_r;
   logic [NUM_CH*BKW-1:0] wr_bank_nxt;

   // link-domain state
   // everything here runs on the controller's clock, pins sampled directly
   logic rd_req_s1_r;
   logic rd_req_s2_r;
   logic rd_seen_r;
   logic rd_seen_nxt;
   logic rd_beat;
   logic [NUM_CH*DQ_W-1:0] dq_o_r;
   logic [NUM_CH*DQ_W-1:0] dq_o_nxt;
   logic [NL-1:0] drive_r;
   logic [NL-1:0] drive_nxt;
   logic [NL-1:0] strobe_r;
   logic [NL-1:0] strobe_nxt;
   logic [NL-1:0] mil_o_r;
   logic [NL-1:0] mil_o_nxt;
   logic [NUM_CH-1:0] wr_tog_r;
   logic [NUM_CH-1:0] wr_tog_nxt;
   logic [NUM_CH*DQ_W-1:0] wr_hold_r;
   logic [NUM_CH*DQ_W-1:0] wr_hold_nxt;
   logic [NL-1:0] keep_hold_r;
   logic [NL-1:0] keep_hold_nxt;
   logic [NUM_CH*BKW-1:0] bank_hold_r;
   logic [NUM_CH*BKW-1:0] bank_hold_nxt;

   // per-byte coder outputs
   logic [NUM_CH*DQ_W-1:0] tx_code;
   logic [NL-1:0] tx_flag;
   logic [NUM_CH*DQ_W-1:0] rx_plain;

   // one coder per byte lane of every channel
   for (genvar g = 0; g < NL; g++) begin : g_lane
      dlm_lane_code u_code (
         .inv_tx_en(inv_rd_l),
         .tx_byte(rd_hold_r[g*BW +: BW]),
         .tx_code(tx_code[g*BW +: BW]),
         .tx_flag(tx_flag[g]),
         .inv_rx_en(inv_wr_l),
         .rx_byte(dq_i[g*BW +: BW]),
         .rx_flag(mask_invert_line_i[g]),
         .rx_plain(rx_plain[g*BW +: BW])
      );
   end

   // core side: read handshake out, write toggles in
   // one read word in flight; no buffer, so a second offer waits for ready
   // ready only once the link has echoed the last request back
   assign rd_ready = (rd_ack_s2_r == rd_req_r);

   always_comb begin
      rd_req_nxt = rd_req_r;
      rd_hold_nxt = rd_hold_r;
      if (rd_valid && rd_ready) begin
         rd_req_nxt = ~rd_req_r;
         rd_hold_nxt = rd_data; // held stable while the link reads it
      end
      wr_valid_nxt = wr_tog_s2_r ^ wr_tog_s3_r;
      wr_data_nxt = wr_data_r;
      wr_keep_nxt = wr_keep_r;
      wr_bank_nxt = wr_bank_r;
      for (int c = 0; c < NUM_CH; c++) begin
         // link hold registers are quiet once their toggle has settled here
         if (wr_valid_nxt[c]) begin
            wr_data_nxt[c*DQ_W +: DQ_W] = wr_hold_r[c*DQ_W +: DQ_W];
            wr_keep_nxt[c*(DQ_W/BW) +: DQ_W/BW] = keep_hold_r[c*(DQ_W/BW) +: DQ_W/BW];
            wr_bank_nxt[c*BKW +: BKW] = bank_hold_r[c*BKW +: BKW];
         end
      end
   end

   // core registers, synchronous reset for all channels at once, except the ack chain and the first two toggle stages
   always_ff @(posedge clk) begin
      rd_ack_s1_r <= rd_seen_r;
      rd_ack_s2_r <= rd_ack_s1_r;
      wr_tog_s1_r <= wr_tog_r;
      wr_tog_s2_r <= wr_tog_s1_r;
      if (!reset_n) begin
         rd_req_r <= 1'b0;
         rd_hold_r <= '0;
         wr_tog_s3_r <= '0;
         wr_valid_r <= '0;
         wr_data_r <= '0;
         wr_keep_r <= '0;
         wr_bank_r <= '0;
      end else begin
         rd_req_r <= rd_req_nxt;
         rd_hold_r <= rd_hold_nxt;
         wr_tog_s3_r <= wr_tog_s2_r;
         wr_valid_r <= wr_valid_nxt;
         wr_data_r <= wr_data_nxt;
         wr_keep_r <= wr_keep_nxt;
         wr_bank_r <= wr_bank_nxt;
      end
   end

   assign wr_valid = wr_valid_r;
   assign wr_data = wr_data_r;
   assign wr_keep = wr_keep_r;
   assign wr_bank = wr_bank_r;

   // link side: read beat out, write capture in
   // a read beat owns the pins; a write in that cycle is dropped, not queued
   assign rd_beat = rd_req_s2_r ^ rd_seen_r;

   always_comb begin
      logic [dlm_pkg::OP_W-1:0] op;
      logic wr_hit;
      logic masked;
      logic strobe_ok;
      op = '0;
      wr_hit = 1'b0;
      masked = 1'b0;
      strobe_ok = 1'b0;
      rd_seen_nxt = rd_req_s2_r;
      // data, strobe and line all change on one edge: edge-aligned read
      dq_o_nxt = rd_beat ? tx_code : dq_o_r;
      drive_nxt = {NL{rd_beat}};
      strobe_nxt = {NL{rd_beat}};
      mil_o_nxt = rd_beat ? tx_flag : mil_o_r;
      wr_tog_nxt = wr_tog_r;
      wr_hold_nxt = wr_hold_r;
      keep_hold_nxt = keep_hold_r;
      bank_hold_nxt = bank_hold_r;
      for (int c = 0; c < NUM_CH; c++) begin
         op = cmd_addr_bus[c*CW + dlm_pkg::OP_LSB +: dlm_pkg::OP_W];
         // controller drives its strobe on the same edge as the data; no strobe, nothing stored
         strobe_ok = &(strobe_t_i[c*(DQ_W/BW) +: DQ_W/BW] & ~strobe_c_i[c*(DQ_W/BW) +: DQ_W/BW]);
         wr_hit = chip_sel[c] && strobe_ok && !rd_beat
            && (op == dlm_pkg::OP_WRITE || op == dlm_pkg::OP_MASK_WRITE);
         masked = (op == dlm_pkg::OP_MASK_WRITE) && mask_en_l;
         if (wr_hit) begin
            wr_tog_nxt[c] = ~wr_tog_r[c];
            bank_hold_nxt[c*BKW +: BKW] = cmd_addr_bus[c*CW + dlm_pkg::BANK_LSB +: BKW];
            for (int b = 0; b < DQ_W / BW; b++) begin
               if (masked) begin
                  // line high marks a byte that must not be stored
                  keep_hold_nxt[c*(DQ_W/BW) + b] = ~mask_invert_line_i[c*(DQ_W/BW) + b];
                  wr_hold_nxt[(c*(DQ_W/BW) + b)*BW +: BW] = dq_i[(c*(DQ_W/BW) + b)*BW +: BW];
               end else begin
                  keep_hold_nxt[c*(DQ_W/BW) + b] = 1'b1;
                  wr_hold_nxt[(c*(DQ_W/BW) + b)*BW +: BW] = rx_plain[(c*(DQ_W/BW) + b)*BW +: BW];
               end
            end
         end
      end
   end

   // link registers; the request synchroniser carries no reset
   always_ff @(posedge clock_true) begin
      rd_req_s1_r <= rd_req_r;
      rd_req_s2_r <= rd_req_s1_r;
      if (!lrst_n) begin
         rd_seen_r <= 1'b0;
         dq_o_r <= {NL{dlm_pkg::DQ_RST}};
         drive_r <= '0;
         strobe_r <= {NL{dlm_pkg::STROBE_RST}};
         mil_o_r <= {NL{dlm_pkg::MASK_LINE_RST}};
         wr_tog_r <= '0;
         wr_hold_r <= '0;
         keep_hold_r <= '0;
         bank_hold_r <= '0;
      end else begin
         rd_seen_r <= rd_seen_nxt;
         dq_o_r <= dq_o_nxt;
         drive_r <= drive_nxt;
         strobe_r <= strobe_nxt;
         mil_o_r <= mil_o_nxt;
         wr_tog_r <= wr_tog_nxt;
         wr_hold_r <= wr_hold_nxt;
         keep_hold_r <= keep_hold_nxt;
         bank_hold_r <= bank_hold_nxt;
      end
   end

   // pin drive: enables per byte lane, complement strobe mirrors true
   always_comb begin
      for (int l = 0; l < NL; l++) begin
         dq_oe[l*BW +: BW] = {BW{drive_r[l]}};
      end
   end

   assign dq_o = dq_o_r;
   assign strobe_t_o = strobe_r;
   assign strobe_c_o = ~strobe_r;
   assign strobe_t_oe = drive_r;
   assign strobe_c_oe = drive_r;
   // line is only driven on reads; a disabled inversion leaves it low
   assign mask_invert_line_o = mil_o_r;
   assign mask_invert_line_oe = drive_r;

endmodule : dlm_data_lane

`default_nettype wire

// ### rtl/dlm_lane_code.sv
// per-byte bus inversion encoder and write-side decoder
`timescale 1ns/100ps
`default_nettype none

module dlm_lane_code (
   // read side: byte to send
   input wire logic inv_tx_en,
   input wire logic [dlm_pkg::BYTE_W-1:0] tx_byte,
   output logic [dlm_pkg::BYTE_W-1:0] tx_code,
   output logic tx_flag,
   // write side: byte as received
   input wire logic inv_rx_en,
   input wire logic [dlm_pkg::BYTE_W-1:0] rx_byte,
   input wire logic rx_flag,
   output logic [dlm_pkg::BYTE_W-1:0] rx_plain
);

   // count of ones in one byte
   function automatic logic [3:0] ones(input logic [dlm_pkg::BYTE_W-1:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < dlm_pkg::BYTE_W; i++) begin
         n = n + {3'h0, b[i]};
      end
      return n;
   endfunction : ones

   // invert when most bits are high, flag follows the inversion
   always_comb begin
      tx_flag = inv_tx_en && (ones(tx_byte) > 4'(dlm_pkg::INV_THRESH));
      tx_code = tx_flag ? ~tx_byte : tx_byte;
   end

   // a high line on the write side means the byte arrived inverted
   always_comb begin
      rx_plain = (inv_rx_en && rx_flag) ? ~rx_byte : rx_byte;
   end

endmodule : dlm_lane_code

`default_nettype wire

// ### testbench/dlm_ctrl_model.sv
// controller model: link clock, write commands, pin resolution
`timescale 1ns/100ps
`default_nettype none

module dlm_ctrl_model (
   // link clock and command pins
   output logic clock_true,
   output logic [1:0] chip_sel,
   output logic [11:0] cmd_addr_bus,
   // resolved pins seen by the die
   output logic [31:0] dq_i,
   output logic [3:0] strobe_t_i,
   output logic [3:0] strobe_c_i,
   output logic [3:0] mask_invert_line_i,
   // die drivers
   input wire logic [31:0] dq_o,
   input wire logic [31:0] dq_oe,
   input wire logic [3:0] strobe_t_o,
   input wire logic [3:0] strobe_t_oe,
   input wire logic [3:0] strobe_c_o,
   input wire logic [3:0] strobe_c_oe,
   input wire logic [3:0] mask_invert_line_o,
   input wire logic [3:0] mask_invert_line_oe
);
   logic [31:0] md;
   logic [3:0] ms;
   logic [3:0] ml;

   // memory clock runs free, reset and read beats need it
   initial begin
      clock_true = 1'b0;
      chip_sel = 2'b00;
      cmd_addr_bus = 12'h000;
      md = 32'h0;
      ms = 4'h0;
      ml = 4'h0;
      #1.7;
      forever #3 clock_true = ~clock_true;
   end

   // wire level from both parties' enables
   assign dq_i = (dq_oe & dq_o) | (~dq_oe & md);
   assign strobe_t_i = (strobe_t_oe & strobe_t_o) | (~strobe_t_oe & ms);
   assign strobe_c_i = (strobe_c_oe & strobe_c_o) | (~strobe_c_oe & ~ms);
   assign mask_invert_line_i = (mask_invert_line_oe & mask_invert_line_o) | (~mask_invert_line_oe & ml);

   // one write beat held over one rising edge, then released to inverse values
   task automatic wr(input int ch, input logic [2:0] op, input logic [2:0] bk, input logic [15:0] d,
                     input logic [1:0] ln);
      @(negedge clock_true);
      chip_sel[ch] = 1'b1;
      cmd_addr_bus[6*ch+:6] = {bk, op};
      md[16*ch+:16] = d;
      ml[2*ch+:2] = ln;
      ms[2*ch+:2] = 2'b11;
      @(negedge clock_true);
      chip_sel = 2'b00;
      cmd_addr_bus = ~cmd_addr_bus;
      md = ~md;
      ml = ~ml;
      ms = 4'h0;
   endtask : wr
endmodule : dlm_ctrl_model

`default_nettype wire

// ### testbench/dlm_data_lane_assertions.sv
// concurrent checks on the data lane block ports
`timescale 1ns/100ps
`default_nettype none

module dlm_data_lane_assertions #(
   parameter int NUM_CH = 2,
   parameter int DQ_W = 16,
   parameter int L = NUM_CH*DQ_W/8
) (
   // core side
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic [NUM_CH-1:0] wr_valid,
   input wire logic [L-1:0] wr_keep,
   // modes
   input wire logic bus_inversion_rd_en,
   input wire logic write_byte_mask_en,
   // link side
   input wire logic clock_true,
   input wire logic [NUM_CH-1:0] chip_sel,
   input wire logic [NUM_CH*dlm_pkg::CMD_W-1:0] cmd_addr_bus,
   input wire logic [NUM_CH*DQ_W-1:0] dq_o,
   input wire logic [NUM_CH*DQ_W-1:0] dq_oe,
   input wire logic [L-1:0] strobe_t_i,
   input wire logic [L-1:0] strobe_t_o,
   input wire logic [L-1:0] strobe_t_oe,
   input wire logic [L-1:0] strobe_c_o,
   input wire logic [L-1:0] mask_invert_line_o
);
   logic [L-1:0] inv_bad;

   // a flagged byte must have few ones left, an unflagged one at most half
   always_comb begin
      for (int l = 0; l < L; l++) begin
         inv_bad[l] = dq_oe[8*l] && ($countones(dq_o[8*l+:8]) > (mask_invert_line_o[l] ? 3 : 4));
      end
   end

   AST_STROBE_PAIR: assert property (@(posedge clock_true) disable iff (!reset_n)
      strobe_c_o == ~strobe_t_o) else $error("strobe pair not complementary");
   AST_BEAT_ALIGN: assert property (@(posedge clock_true) disable iff (!reset_n)
      |strobe_t_oe |-> &dq_oe && &strobe_t_oe && &strobe_t_o) else $error("strobe not aligned with data");
   AST_BEAT_ONE: assert property (@(posedge clock_true) disable iff (!reset_n)
      $rose(strobe_t_oe[0]) |=> !strobe_t_oe[0] && strobe_t_o == '0) else $error("read beat too long");
   AST_INV_FLAG: assert property (@(posedge clock_true) disable iff (!reset_n)
      bus_inversion_rd_en && $past(bus_inversion_rd_en, 4) |-> inv_bad == '0) else $error("inversion flag wrong");
   AST_INV_OFF: assert property (@(posedge clock_true) disable iff (!reset_n)
      dq_oe[0] && !bus_inversion_rd_en && !$past(bus_inversion_rd_en, 4) |-> mask_invert_line_o == '0)
      else $error("inversion flagged while off");
   // reset is the subject here, so it is not the disable condition
   AST_LINK_RESET: assert property (@(posedge clock_true)
      !reset_n [*6] |-> dq_oe == '0 && strobe_t_oe == '0 && strobe_c_o == '1) else $error("link not reset");
   AST_CORE_RESET: assert property (@(posedge clk)
      !reset_n |=> wr_valid == '0 && wr_keep == '0) else $error("core side not reset");
   AST_RD_TAKE: assert property (@(posedge clk) disable iff (!reset_n)
      rd_valid && rd_ready |=> !rd_ready [*2]) else $error("second read taken too early");
   AST_WR_TAKE: assert property (@(posedge clock_true) disable iff (!reset_n)
      chip_sel[0] && cmd_addr_bus[2:0] inside {3'h1, 3'h2} && strobe_t_i[1:0] == 2'b11 && !dq_oe[0]
      |-> ##[1:20] wr_valid[0]) else $error("write command lost");
   AST_WR_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(wr_valid[1]) |=> !wr_valid[1]) else $error("write pulse too long");
   AST_KEEP_OFF: assert property (@(posedge clk) disable iff (!reset_n)
      wr_valid[1] && !write_byte_mask_en && !$past(write_byte_mask_en, 8) |-> wr_keep[3:2] == 2'b11)
      else $error("bytes masked while masking off");

   // main scenarios reached
   CV_READ: cover property (@(posedge clock_true) $rose(strobe_t_oe[0]));
   CV_FLAG: cover property (@(posedge clock_true) dq_oe[0] && mask_invert_line_o[0]);
   CV_MASK: cover property (@(posedge clk) wr_valid[0] && wr_keep[1:0] != 2'b11);
endmodule : dlm_data_lane_assertions

bind dlm_data_lane dlm_data_lane_assertions #(.NUM_CH(NUM_CH), .DQ_W(DQ_W)) ast_i (.clk, .reset_n, .rd_valid,
   .rd_ready, .wr_valid, .wr_keep, .bus_inversion_rd_en, .write_byte_mask_en, .clock_true, .chip_sel,
   .cmd_addr_bus, .dq_o, .dq_oe, .strobe_t_i, .strobe_t_o, .strobe_t_oe, .strobe_c_o, .mask_invert_line_o);

`default_nettype wire

// ### testbench/dlm_data_lane_tb_top.sv
// self-checking testbench for the data lane block
`timescale 1ns/100ps
`default_nettype none

module dlm_data_lane_tb_top;
   logic clk, reset_n, rd_valid, rd_ready, clock_true;
   logic bus_inversion_rd_en, bus_inversion_wr_en, write_byte_mask_en;
   logic [1:0] wr_valid, chip_sel;
   logic [31:0] rd_data, wr_data, dq_i, dq_o, dq_oe;
   logic [3:0] wr_keep, strobe_t_i, strobe_t_o, strobe_t_oe, strobe_c_i, strobe_c_o, strobe_c_oe;
   logic [3:0] mask_invert_line_i, mask_invert_line_o, mask_invert_line_oe;
   logic [5:0] wr_bank;
   logic [11:0] cmd_addr_bus;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   dlm_data_lane dlm_data_lane_i (.clk, .reset_n, .rd_valid, .rd_data, .rd_ready, .wr_valid, .wr_data, .wr_keep,
      .wr_bank, .bus_inversion_rd_en, .bus_inversion_wr_en, .write_byte_mask_en, .clock_true, .chip_sel,
      .cmd_addr_bus, .dq_i, .dq_o, .dq_oe, .strobe_t_i, .strobe_t_o, .strobe_t_oe, .strobe_c_i, .strobe_c_o,
      .strobe_c_oe, .mask_invert_line_i, .mask_invert_line_o, .mask_invert_line_oe);
   dlm_ctrl_model dlm_ctrl_model_i (.clock_true, .chip_sel, .cmd_addr_bus, .dq_i, .strobe_t_i, .strobe_c_i,
      .mask_invert_line_i, .dq_o, .dq_oe, .strobe_t_o, .strobe_t_oe, .strobe_c_o, .strobe_c_oe,
      .mask_invert_line_o, .mask_invert_line_oe);

   // core clock and hang guard, the tests need under two hundred cycles
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic t_reset;
      @(negedge clk);
      reset_n = 1'b0;
      repeat (20) @(negedge clk);
      chk("wr_data", 32'h0, wr_data);
      chk("wr_keep", 4'h0, wr_keep);
      chk("dq_oe", 32'h0, dq_oe);
      chk("strobe_c_o", 4'hf, strobe_c_o);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      $display("test reset done");
   endtask : t_reset

   // expected read beat: bytes with more than four ones go inverted
   task automatic t_read(input logic [31:0] d, input logic inv);
      logic [31:0] ed;
      logic [3:0] ef;
      int n;
      ed = d;
      ef = 4'h0;
      for (int l = 0; l < 4; l++) begin
         if (inv && $countones(d[8*l+:8]) > 4) begin
            ed[8*l+:8] = ~d[8*l+:8];
            ef[l] = 1'b1;
         end
      end
      @(negedge clk);
      bus_inversion_rd_en = inv;
      repeat (6) @(negedge clk);
      rd_data = d;
      rd_valid = 1'b1;
      for (n = 0; rd_ready !== 1'b1 && n < 20; n++) begin
         @(negedge clk);
      end
      @(negedge clk);
      rd_valid = 1'b0;
      for (n = 0; strobe_t_oe !== 4'hf && n < 40; n++) begin
         @(negedge clock_true);
      end
      chk("dq_o", ed, dq_o);
      chk("line_o", ef, mask_invert_line_o);
      chk("dq_oe", 32'hffffffff, dq_oe);
      chk("strobes", 8'h0f, {strobe_c_o, strobe_t_o});
      chk("oe", 32'hfff, {strobe_t_oe, strobe_c_oe, mask_invert_line_oe});
      $display("test read %h done", d);
   endtask : t_read

   task automatic t_wr(input int ch, input logic [2:0] op, input logic [2:0] bk, input logic [15:0] d,
                       input logic [1:0] ln, input logic inv, input logic msk);
      logic [15:0] ed;
      logic [1:0] ek;
      logic m;
      int n;
      m = op == 3'h2 && msk;
      ek = m ? ~ln : 2'b11;
      for (int b = 0; b < 2; b++) begin
         ed[8*b+:8] = (!m && inv && ln[b]) ? ~d[8*b+:8] : d[8*b+:8];
      end
      @(negedge clk);
      bus_inversion_wr_en = inv;
      write_byte_mask_en = msk;
      repeat (6) @(negedge clk);
      dlm_ctrl_model_i.wr(ch, op, bk, d, ln);
      for (n = 0; wr_valid[ch] !== 1'b1 && n < 20; n++) begin
         @(negedge clk);
      end
      chk("wr_data", ed, wr_data[16*ch+:16]);
      chk("wr_keep", ek, wr_keep[2*ch+:2]);
      chk("wr_bank", bk, wr_bank[3*ch+:3]);
      $display("test write ch %0d op %h done", ch, op);
   endtask : t_wr

   task automatic results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      rd_valid = 1'b0;
      rd_data = 32'h0;
      bus_inversion_rd_en = 1'b0;
      bus_inversion_wr_en = 1'b0;
      write_byte_mask_en = 1'b0;
      t_reset();
      t_read(32'h1f0fff00, 1'b1);
      t_read(32'h1f0fff00, 1'b0);
      t_read(32'hfe017f80, 1'b1);
      t_wr(0, 3'h1, 3'h7, 16'ha5c3, 2'b01, 1'b1, 1'b1);
      t_wr(0, 3'h1, 3'h0, 16'h3c5a, 2'b11, 1'b0, 1'b0);
      t_wr(0, 3'h2, 3'h2, 16'h1234, 2'b10, 1'b1, 1'b1);
      t_wr(1, 3'h2, 3'h5, 16'h5678, 2'b01, 1'b1, 1'b0);
      t_reset();
      results();
   end
endmodule : dlm_data_lane_tb_top

`default_nettype wire
